// ==== rtl/srd_pkg.sv ====
// Behaviour
// - Read starts like write, read bit one
// - Counter holds last address plus one
// - Matching read control byte: acknowledge, send byte
// - Master NACK and STOP end transmission
// - Repeated START abandons write, keeps pointer
// - Read control after restart sends loaded byte
// - After random read pointer is next byte
// - Master ACK requests next sequential byte
// - Pointer increments after each byte transfer; code steps it only as each read byte is loaded for sending
// - Pointer wraps from top to bottom
// - Respond only on type and select match
// - Address high byte first, thirteen bits used
// - After master NACK leave line released
// - Acknowledger holds line low through ninth clock
package srd_pkg;
  localparam int          SRD_ADDR_W   = 13;
  localparam int          SRD_BYTE_W   = 8;
  localparam int          SRD_HI_W     = 5;
  localparam int          SRD_CS_W     = 3;
  localparam logic [12:0] SRD_PTR_RST  = 13'h0000;
  localparam logic [12:0] SRD_PTR_TOP  = 13'h1fff;
  localparam logic [12:0] SRD_PTR_ONE  = 13'h0001;
  localparam logic [3:0]  SRD_CNT_RST  = 4'h0;
  localparam logic [3:0]  SRD_BIT_FIRST = 4'h1;
  localparam logic [3:0]  SRD_BIT_LAST = 4'h7;
  localparam logic [3:0]  SRD_BIT_ACK  = 4'h8;
  localparam logic [3:0]  SRD_CNT_ONE  = 4'h1;
  // Reset value differs from the fetch side so a first fetch of address zero starts
  localparam logic        SRD_REQ_RST  = 1'b1;
  localparam logic        SRD_ACK_RST  = 1'b0;
  localparam logic [7:0]  SRD_BYTE_RST = 8'h00;
  // Device type code: value is arbitrary
  localparam logic [3:0]  SRD_DEV_TYPE_DFLT = 4'h9;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_CTRL  = 6'h02,
    ST_AHI   = 6'h04,
    ST_ALO   = 6'h08,
    ST_WDATA = 6'h10,
    ST_TX    = 6'h20
  } srd_state_t;

  typedef struct packed {
    logic [SRD_ADDR_W-1:0] addr;
    logic [SRD_BYTE_W-1:0] data;
  } srd_load_t;
endpackage

// ==== rtl/srd_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module srd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : g_chk
    $error("srd_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/srd_mem.sv ====
`timescale 1ns/1ns
`default_nettype none
module srd_mem
  import srd_pkg::*;
#(
  parameter int ADDR_W = SRD_ADDR_W,
  parameter int DATA_W = SRD_BYTE_W
) (
  input  wire logic              clk_in,
  input  wire logic              wr_en_in,
  input  wire logic [ADDR_W-1:0] wr_addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic              rd_en_in,
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output logic      [DATA_W-1:0] rd_data_out
);
  logic [DATA_W-1:0] mem_r [2**ADDR_W];

  if (ADDR_W < 1 || ADDR_W > 16 || DATA_W < 1) begin : g_chk
    $error("srd_mem: unsupported geometry");
  end

  // Array carries no reset; contents come only through the preload port
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rd_en_in) begin
      rd_data_out <= mem_r[rd_addr_in];
    end
  end
endmodule
`default_nettype wire

// ==== rtl/srd_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module srd_top
  import srd_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = SRD_DEV_TYPE_DFLT
) (
  input  wire logic      core_clk_in,
  input  wire logic      rstn_in,
  input  wire logic      scl_in,
  input  wire logic      sda_in,
  output logic           sda_out,
  output logic           sda_oe_out,
  input  wire logic      chip_select_bit_2_in,
  input  wire logic      chip_select_bit_1_in,
  input  wire logic      chip_select_bit_0_in,
  input  wire logic      load_valid_in,
  input  wire srd_load_t load_in
);
  srd_state_t                  st_r;
  logic [3:0]                  cnt_r;
  logic [SRD_BYTE_W-1:0]       rx_sh_r;
  logic [SRD_BYTE_W-1:0]       tx_sh_r;
  logic [SRD_HI_W-1:0]         hi_r;
  logic [SRD_ADDR_W-1:0]       ptr_r;
  logic                        ack_r;
  logic                        rw_r;
  logic                        req_tog_r;
  logic                        start_tog_r;
  logic                        stop_tog_r;
  logic                        start_seen_r;
  logic                        start_now_r;
  logic                        stop_seen_r;
  logic                        drive_r;
  logic                        drive_nxt;
  logic [SRD_CS_W-1:0]         cs_q;
  logic                        ack_q;
  logic [SRD_BYTE_W-1:0]       byte_in;
  logic                        byte_done;
  logic                        ack_slot;
  logic                        stop_now;
  logic                        bus_ok;
  logic                        ctrl_match;
  logic                        rx_st;
  logic                        load_now;
  logic                        fetch_ok;
  srd_state_t                  rx_next;
  logic                        req_q;
  logic                        seen_r;
  logic                        fire;
  logic                        rd_en_r;
  logic                        ack_pend_r;
  logic                        ack_tog_r;
  logic [SRD_BYTE_W-1:0]       mem_data;
  logic [SRD_BYTE_W-1:0]       fetch_data_r;

  // Bus conditions are edges of the data line while the clock line is high
  always_ff @(negedge sda_in or negedge rstn_in) begin
    if (!rstn_in) begin
      start_tog_r <= 1'b0;
    end else if (scl_in) begin
      start_tog_r <= ~start_tog_r;
    end
  end

  always_ff @(posedge sda_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stop_tog_r <= 1'b0;
    end else if (scl_in) begin
      stop_tog_r <= ~stop_tog_r;
    end
  end

  // Chip select straps are static but still pass two flops before use
  srd_sync #(.WIDTH(SRD_CS_W)) u_cs_sync (
    .clk_in  (scl_in),
    .rstn_in (rstn_in),
    .d_in    ({chip_select_bit_2_in, chip_select_bit_1_in, chip_select_bit_0_in}),
    .q_out   (cs_q)
  );

  srd_sync #(.WIDTH(1)) u_ack_sync (
    .clk_in  (scl_in),
    .rstn_in (rstn_in),
    .d_in    (ack_tog_r),
    .q_out   (ack_q)
  );

  // The toggles change only while the clock line is high, so they are
  // settled at the next clock edge by the bus hold times
  assign stop_now   = stop_tog_r ^ stop_seen_r;
  assign bus_ok     = !start_now_r && !stop_now;
  assign byte_in    = {rx_sh_r[SRD_BYTE_W-2:0], sda_in};
  assign byte_done  = (cnt_r == SRD_BIT_LAST);
  assign ack_slot   = (cnt_r == SRD_BIT_ACK);
  assign rx_st      = (st_r == ST_CTRL) || (st_r == ST_AHI) ||
                      (st_r == ST_ALO) || (st_r == ST_WDATA);
  assign fetch_ok   = (ack_q == req_tog_r);
  assign ctrl_match = (byte_in[7:4] == DEV_TYPE) && (byte_in[3:1] == cs_q);
  assign load_now   = bus_ok && ack_slot &&
                      (((st_r == ST_CTRL) && ack_r && rw_r) || ((st_r == ST_TX) && !sda_in));

  always_comb begin
    unique case (st_r)
      ST_CTRL:  rx_next = !ack_r ? ST_IDLE : (rw_r ? ST_TX : ST_AHI);
      ST_AHI:   rx_next = ST_ALO;
      ST_ALO:   rx_next = ST_WDATA;
      default:  rx_next = ST_IDLE;
    endcase
  end

  always_ff @(negedge scl_in or negedge rstn_in) begin
    if (!rstn_in) begin
      start_seen_r <= 1'b0;
      start_now_r  <= 1'b0;
    end else begin
      start_seen_r <= start_tog_r;
      start_now_r  <= start_tog_r ^ start_seen_r;
    end
  end

  always_ff @(posedge scl_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stop_seen_r <= 1'b0;
    end else begin
      stop_seen_r <= stop_tog_r;
    end
  end

  // Frame sequencer
  always_ff @(posedge scl_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r  <= ST_IDLE;
      cnt_r <= SRD_CNT_RST;
    end else if (start_now_r) begin
      st_r  <= ST_CTRL;
      cnt_r <= SRD_BIT_FIRST;
    end else if (stop_now) begin
      st_r  <= ST_IDLE;
      cnt_r <= SRD_CNT_RST;
    end else if (st_r == ST_TX) begin
      if (!ack_slot) begin
        cnt_r <= cnt_r + SRD_CNT_ONE;
      end else if (!sda_in) begin
        cnt_r <= SRD_CNT_RST;
      end else begin
        st_r  <= ST_IDLE;
        cnt_r <= SRD_CNT_RST;
      end
    end else if (rx_st) begin
      if (!ack_slot) begin
        cnt_r <= cnt_r + SRD_CNT_ONE;
      end else begin
        st_r  <= rx_next;
        cnt_r <= SRD_CNT_RST;
      end
    end
  end

  always_ff @(posedge scl_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_sh_r <= SRD_BYTE_RST;
    end else if (start_now_r) begin
      rx_sh_r <= {7'h00, sda_in};
    end else if (rx_st && !ack_slot) begin
      rx_sh_r <= byte_in;
    end
  end

  // Write data is never acknowledged, since the write path is not built here
  always_ff @(posedge scl_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_r <= 1'b0;
      rw_r  <= 1'b0;
    end else if (bus_ok && byte_done && rx_st) begin
      ack_r <= (st_r == ST_CTRL) ? ctrl_match : ((st_r == ST_AHI) || (st_r == ST_ALO));
      if (st_r == ST_CTRL) begin
        rw_r <= byte_in[0];
      end
    end
  end

  always_ff @(posedge scl_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hi_r <= '0;
    end else if (bus_ok && byte_done && (st_r == ST_AHI)) begin
      hi_r <= byte_in[SRD_HI_W-1:0];
    end
  end

  // Pointer names the byte already prefetched, i.e. last accessed plus one
  // last read plus one
  always_ff @(posedge scl_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ptr_r     <= SRD_PTR_RST;
      req_tog_r <= SRD_REQ_RST;
    end else if (bus_ok && byte_done && (st_r == ST_ALO)) begin
      ptr_r     <= {hi_r, byte_in};
      req_tog_r <= ~req_tog_r;
    end else if (load_now) begin
      ptr_r     <= ptr_r + SRD_PTR_ONE;
      req_tog_r <= ~req_tog_r;
    end
  end

  always_ff @(posedge scl_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_sh_r <= SRD_BYTE_RST;
    end else if (load_now) begin
      tx_sh_r <= fetch_data_r;
    end else if ((st_r == ST_TX) && !ack_slot) begin
      tx_sh_r <= {tx_sh_r[SRD_BYTE_W-2:0], 1'b0};
    end
  end

  always_comb begin
    drive_nxt = 1'b0;
    if (st_r == ST_TX) begin
      drive_nxt = !ack_slot && !tx_sh_r[SRD_BYTE_W-1];
    end else if (rx_st && ack_slot && ack_r) begin
      drive_nxt = 1'b1;
    end
  end

  always_ff @(negedge scl_in or negedge rstn_in) begin
    if (!rstn_in) begin
      drive_r <= 1'b0;
    end else if (start_tog_r ^ start_seen_r) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  assign sda_oe_out = drive_r && !stop_now;
  assign sda_out    = 1'b0;

  // Fetch side: one handshake per pointer change; data stays put until the next request
  srd_sync #(.WIDTH(1)) u_req_sync (
    .clk_in  (core_clk_in),
    .rstn_in (rstn_in),
    .d_in    (req_tog_r),
    .q_out   (req_q)
  );

  assign fire = req_q ^ seen_r;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      seen_r     <= SRD_ACK_RST;
      rd_en_r    <= 1'b0;
      ack_pend_r <= SRD_ACK_RST;
    end else begin
      seen_r  <= req_q;
      rd_en_r <= fire;
      if (fire) begin
        ack_pend_r <= req_q;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fetch_data_r <= SRD_BYTE_RST;
      ack_tog_r    <= SRD_ACK_RST;
    end else if (rd_en_r) begin
      fetch_data_r <= mem_data;
      ack_tog_r    <= ack_pend_r;
    end
  end

  srd_mem #(.ADDR_W(SRD_ADDR_W), .DATA_W(SRD_BYTE_W)) u_mem (
    .clk_in      (core_clk_in),
    .wr_en_in    (load_valid_in),
    .wr_addr_in  (load_in.addr),
    .wr_data_in  (load_in.data),
    .rd_en_in    (fire),
    .rd_addr_in  (ptr_r),
    .rd_data_out (mem_data)
  );

  sequence s_ctrl_read;
    (st_r == ST_CTRL) && ack_slot && ack_r && rw_r && bus_ok;
  endsequence

  sequence s_master_ack;
    (st_r == ST_TX) && ack_slot && !sda_in && bus_ok;
  endsequence

  a_start_to_ctrl: assert property (
    @(posedge scl_in) disable iff (!rstn_in)
    start_now_r |=> (st_r == ST_CTRL) && (cnt_r == SRD_BIT_FIRST))
    else $error("START did not open a control byte");

  a_ctrl_match_ack: assert property (
    @(posedge scl_in) disable iff (!rstn_in)
    ((st_r == ST_CTRL) && byte_done && bus_ok) |=> (ack_r == $past(ctrl_match)))
    else $error("control byte acknowledge does not follow match");

  a_read_enters_tx: assert property (
    @(posedge scl_in) disable iff (!rstn_in)
    s_ctrl_read |=> (st_r == ST_TX) && (cnt_r == SRD_CNT_RST) && (tx_sh_r == $past(fetch_data_r)))
    else $error("read control byte did not start transmission");

  a_fetch_ready: assert property (
    @(posedge scl_in) disable iff (!rstn_in)
    (s_ctrl_read or s_master_ack) |-> fetch_ok)
    else $error("byte loaded before its fetch finished");

  a_ack_drive: assert property (
    @(posedge scl_in) disable iff (!rstn_in)
    (rx_st && ack_slot && ack_r && bus_ok) |-> sda_oe_out)
    else $error("acknowledge not held low in ninth clock");

  a_nack_release: assert property (
    @(posedge scl_in) disable iff (!rstn_in)
    ((st_r == ST_TX) && ack_slot && sda_in && bus_ok) |-> !sda_oe_out ##1 (st_r == ST_IDLE) && !drive_r)
    else $error("line not released after master NACK");

  a_seq_next: assert property (
    @(posedge scl_in) disable iff (!rstn_in)
    s_master_ack |=> (st_r == ST_TX) && (cnt_r == SRD_CNT_RST) && (tx_sh_r == $past(fetch_data_r)))
    else $error("master ACK did not start the next byte");

  a_ptr_step: assert property (
    @(posedge scl_in) disable iff (!rstn_in)
    load_now |=> ((ptr_r - $past(ptr_r)) == SRD_PTR_ONE) && (req_tog_r != $past(req_tog_r)))
    else $error("pointer did not step by one after a byte");

  a_ptr_wrap: assert property (
    @(posedge scl_in) disable iff (!rstn_in)
    (load_now && (ptr_r == SRD_PTR_TOP)) |=> (ptr_r == SRD_PTR_RST))
    else $error("pointer did not wrap from top to bottom");

  a_addr_load: assert property (
    @(posedge scl_in) disable iff (!rstn_in)
    ((st_r == ST_ALO) && byte_done && bus_ok) |=> (ptr_r == {$past(hi_r), $past(byte_in)}))
    else $error("word address not loaded high byte first");

  a_restart_keep: assert property (
    @(posedge scl_in) disable iff (!rstn_in)
    ((st_r == ST_WDATA) && start_now_r) |=> (ptr_r == $past(ptr_r)) && (st_r == ST_CTRL))
    else $error("repeated START lost the loaded pointer");

  a_stop_idle: assert property (
    @(posedge scl_in) disable iff (!rstn_in)
    (stop_now && !start_now_r) |-> !sda_oe_out ##1 (st_r == ST_IDLE))
    else $error("STOP did not release and idle");

  a_idle_quiet: assert property (
    @(posedge scl_in) disable iff (!rstn_in)
    ((st_r == ST_IDLE) && ($past(st_r) == ST_IDLE)) |-> !drive_r)
    else $error("line driven while idle");

  a_fetch_turn: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    fire |=> rd_en_r ##1 (ack_tog_r == $past(req_q, 2)))
    else $error("fetch did not answer in two cycles");
endmodule
`default_nettype wire

// ==== tb/srd_i2c_master.sv ====
`timescale 1ns/1ns
`default_nettype none
module srd_i2c_master (
  output logic      scl_out,
  output logic      pull_out,
  input  wire logic sda_in
);
  // Extra low time per bit, so the master can run slow
  int stretch_ns;

  initial begin
    scl_out = 1'h1;
    pull_out = 1'h0;
    stretch_ns = 0;
  end

  // Data only moves while the clock is low
  task automatic send_bit(input logic b);
    #(7 + stretch_ns) pull_out = ~b;
    #8 scl_out = 1'h1;
    #15 scl_out = 1'h0;
  endtask

  task automatic recv_bit(output logic b);
    #(7 + stretch_ns) pull_out = 1'h0;
    #8 scl_out = 1'h1;
    #7 b = sda_in;
    #8 scl_out = 1'h0;
  endtask

  task automatic start_cond();
    #7 pull_out = 1'h0;
    #8 scl_out = 1'h1;
    #7 pull_out = 1'h1;
    #8 scl_out = 1'h0;
  endtask

  task automatic stop_cond();
    #7 pull_out = 1'h1;
    #8 scl_out = 1'h1;
    #7 pull_out = 1'h0;
    #8 scl_out = 1'h1;
  endtask

  // Bare clock pulse on an idle bus carries no condition
  task automatic idle_pulse();
    #7 scl_out = 1'h0;
    #15 scl_out = 1'h1;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i]);
    end
    recv_bit(ack);
  endtask

  task automatic rd_byte(input logic ack_bit, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      recv_bit(b);
      d[i] = b;
    end
    send_bit(ack_bit);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_serial_eeprom_read_path.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_serial_eeprom_read_path
  import srd_pkg::*;
;
  localparam int TIMEOUT_CYC = 20000;
  logic       core_clk;
  logic       rstn;
  logic       load_valid;
  srd_load_t  load;
  logic [2:0] cs_pins;
  logic       m_scl;
  logic       m_pull;
  logic       sda_w;
  logic       sda_o;
  logic       sda_oe;
  int         err_total = 0;
  int         checks_done = 0;
  int         cyc = 0;

  // Open-drain wire with pull-up
  assign sda_w = (m_pull || (sda_oe && (sda_o == 1'h0))) ? 1'h0 : 1'h1;

  srd_top DUT (
    .core_clk_in          (core_clk),
    .rstn_in              (rstn),
    .scl_in               (m_scl),
    .sda_in               (sda_w),
    .sda_out              (sda_o),
    .sda_oe_out           (sda_oe),
    .chip_select_bit_2_in (cs_pins[2]),
    .chip_select_bit_1_in (cs_pins[1]),
    .chip_select_bit_0_in (cs_pins[0]),
    .load_valid_in        (load_valid),
    .load_in              (load)
  );

  srd_i2c_master u_m (
    .scl_out  (m_scl),
    .pull_out (m_pull),
    .sda_in   (sda_w)
  );

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [7:0] pat(input logic [12:0] a);
    return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h5a;
  endfunction

  function automatic logic [7:0] ctrl(input logic [2:0] cs, input logic rw);
    return {SRD_DEV_TYPE_DFLT, cs, rw};
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic preload();
    logic [12:0] q[$];
    q = '{13'h0001, 13'h0002, 13'h0003, 13'h0004, 13'h0123, 13'h0124, 13'h1ffd, 13'h1ffe, 13'h1fff, 13'h0000};
    foreach (q[i]) begin
      @(posedge core_clk);
      load_valid <= 1'h1;
      load <= '{addr: q[i], data: pat(q[i])};
    end
    @(posedge core_clk);
    load_valid <= 1'h0;
  endtask

  // Upper three bits of the high byte are junk on purpose
  task automatic set_addr(input logic [12:0] a);
    logic ack;
    u_m.start_cond();
    u_m.wr_byte(ctrl(cs_pins, 1'h0), ack);
    check("write control ack", {7'h0, ack}, 8'h00);
    u_m.wr_byte({3'h7, a[12:8]}, ack);
    check("address high ack", {7'h0, ack}, 8'h00);
    u_m.wr_byte(a[7:0], ack);
    check("address low ack", {7'h0, ack}, 8'h00);
  endtask

  task automatic read_n(input int n, input logic [12:0] a);
    logic       ack;
    logic [7:0] d;
    u_m.start_cond();
    u_m.wr_byte(ctrl(cs_pins, 1'h1), ack);
    check("read control ack", {7'h0, ack}, 8'h00);
    for (int k = 0; k < n; k++) begin
      u_m.rd_byte(k == n - 1, d);
      check("read data", d, pat(a + 13'(k)));
    end
    check("released after nack", {7'h0, sda_oe}, 8'h00);
    u_m.stop_cond();
  endtask

  task automatic t_select();
    logic [2:0] pins [4];
    logic [7:0] cb [4];
    logic       exp [4];
    logic       ack;
    pins = '{3'h5, 3'h5, 3'h2, 3'h2};
    cb = '{ctrl(3'h5, 1'h1) ^ 8'h10, ctrl(3'h4, 1'h1), ctrl(3'h2, 1'h0), ctrl(3'h5, 1'h0)};
    exp = '{1'h1, 1'h1, 1'h0, 1'h1};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      cs_pins <= pins[i];
      repeat (4) @(posedge core_clk);
      u_m.start_cond();
      u_m.wr_byte(cb[i], ack);
      check("select ack", {7'h0, ack}, {7'h0, exp[i]});
      u_m.stop_cond();
      repeat (2) u_m.idle_pulse();
      check("idle after stop", {7'h0, sda_oe}, 8'h00);
    end
    @(posedge core_clk);
    cs_pins <= 3'h5;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic t_random();
    set_addr(13'h0123);
    read_n(1, 13'h0123);
    read_n(1, 13'h0124);
  endtask

  task automatic t_seq_wrap();
    u_m.stretch_ns = 40;
    set_addr(13'h1ffd);
    read_n(5, 13'h1ffd);
    u_m.stretch_ns = 0;
    read_n(1, 13'h0002);
  endtask

  task automatic t_restart();
    logic [7:0] cb;
    cb = ctrl(cs_pins, 1'h1);
    u_m.start_cond();
    for (int i = 0; i < 3; i++) begin
      u_m.send_bit(cb[7 - i]);
    end
    read_n(1, 13'h0003);
  endtask

  task automatic t_no_write();
    logic ack;
    set_addr(13'h0004);
    u_m.wr_byte(8'h77, ack);
    check("write data refused", {7'h0, ack}, 8'h01);
    u_m.stop_cond();
    set_addr(13'h0004);
    read_n(1, 13'h0004);
  endtask

  initial begin
    forever begin
      @(posedge core_clk);
      cyc++;
      if (cyc >= TIMEOUT_CYC) begin
        err_total++;
        final_report();
      end
    end
  end

  initial begin
    rstn = 1'h1;
    load_valid = 1'h0;
    load = '0;
    cs_pins = 3'h5;
    // Reset falls after time zero so every async reset sees its edge
    @(posedge core_clk);
    rstn <= 1'h0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'h1;
    repeat (10) @(posedge core_clk);
    preload();
    repeat (10) @(posedge core_clk);
    t_select();
    t_random();
    t_seq_wrap();
    t_restart();
    t_no_write();
    final_report();
  end
endmodule
`default_nettype wire
